/* rtl/cdt_map.vh */
// constants for the opcode decode and timing block
`ifndef CDT_MAP_VH
`define CDT_MAP_VH
// register byte addresses
`define CDT_REG_CTRL 8'h00
`define CDT_REG_INSN 8'h04
`define CDT_REG_CTX 8'h08
`define CDT_REG_STAT 8'h0C
`define CDT_REG_CLKS 8'h10
`define CDT_REG_FLAGS 8'h14
// control bits
`define CDT_CTRL_PROT 0
`define CDT_CTRL_RESET 32'h0000_0000
// context bits
`define CDT_CTX_TAKEN 0
`define CDT_CTX_INDEX 1
`define CDT_CTX_MEM 2
`define CDT_CTX_PRIV 3
`define CDT_CTX_CNT_LO 8
// flag mask bit positions
`define CDT_F_CARRY 0
`define CDT_F_PARITY 2
`define CDT_F_AUX 4
`define CDT_F_ZERO 6
`define CDT_F_SIGN 7
`define CDT_F_OVER 11
`define CDT_F_ALL 16'h08D5
`define CDT_F_ALLCTL 16'h0FD5
// exception vector
`define CDT_VEC_INVALID 8'h06
// instruction classes
`define CDT_C_NONE 5'h00
`define CDT_C_PREFIX 5'h01
`define CDT_C_JCC 5'h02
`define CDT_C_FLAGSAH 5'h03
`define CDT_C_ARFETCH 5'h04
`define CDT_C_LIMFETCH 5'h05
`define CDT_C_FARPTR 5'h06
`define CDT_C_ADDR 5'h07
`define CDT_C_GIDT 5'h08
`define CDT_C_LDTTR 5'h09
`define CDT_C_MSW 5'h0A
`define CDT_C_LOOP 5'h0B
`define CDT_C_CRWR 5'h0C
`define CDT_C_CRRD 5'h0D
`define CDT_C_DRWR 5'h0E
`define CDT_C_DRRD 5'h0F
`define CDT_C_TRWR 5'h10
`define CDT_C_TRRD 5'h11
`define CDT_C_SEXT 5'h12
`define CDT_C_ZEXT 5'h13
`define CDT_C_POPSEG 5'h14
`define CDT_C_POPGEN 5'h15
`define CDT_C_STACK_PULL_FLAGS 5'h16
`define CDT_C_STACK_PULL_ALL 5'h17
`define CDT_C_PUSH 5'h18
`define CDT_C_STACK_STORE_ALL 5'h19
`define CDT_C_RCx 5'h1A
`define CDT_C_STRING 5'h1B
`define CDT_C_RETN 5'h1C
`define CDT_C_RETF 5'h1D
`define CDT_C_SMRST 5'h1E
`define CDT_C_SMEXIT 5'h1F
`endif

/* rtl/cdt_decode.v */
// opcode decode and execution timing with an axi4-lite register port
`timescale 1ns/1ps
`include "cdt_map.vh"
module cdt_decode (
	input wire aclk,
	input wire aresetn,
	input wire aclk_en,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	// software state
	reg [31:0] ctrl;
	reg [31:0] insn;
	reg [31:0] ctx;
	// decode results, registered when an instruction word is written
	reg [4:0] cls;
	reg [3:0] cond;
	reg invalid;
	reg [15:0] clocks;
	reg [15:0] flag_mask;
	reg [7:0] vector;
	reg [1:0] prefix_cnt;
	reg [2:0] disp_bytes;
	// write channel capture, taken in either order
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire prot = ctrl[`CDT_CTRL_PROT];
	wire taken = ctx[`CDT_CTX_TAKEN];
	wire use_index = ctx[`CDT_CTX_INDEX];
	wire use_mem = ctx[`CDT_CTX_MEM];
	wire cross_priv = ctx[`CDT_CTX_PRIV];
	wire [15:0] n_cnt = ctx[`CDT_CTX_CNT_LO +: 16];
	// axi write path: address and data are held until both are present
	wire wr_go = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire wr_insn = wr_go && aw_addr == `CDT_REG_INSN;
	// the decoder looks at the word being written so results land with it
	wire [31:0] next_insn = wr_insn ? ((insn & ~wmask) | (w_data & wmask)) : insn;
	// combinational decode of the pending instruction word
	reg [4:0] d_cls;
	reg [3:0] d_cond;
	reg d_prot_only;
	reg [15:0] d_clk;
	reg [15:0] d_flags;
	reg [1:0] d_pfx;
	reg [2:0] d_disp;
	reg [7:0] b0;
	reg [7:0] b1;
	reg [7:0] b2;
	reg [2:0] mreg;
	reg is_pfx;
	// strip at most one leading prefix other than F2 or F3, then classify the opcode
	always @* begin
		b0 = next_insn[7:0];
		b1 = next_insn[15:8];
		b2 = next_insn[23:16];
		d_pfx = 2'd0;
		// prefixes other than F2 and F3 are counted and skipped, they alter no flag
		case (b0)
			8'hF0, 8'h67, 8'h66, 8'h2E, 8'h3E, 8'h26, 8'h64, 8'h65, 8'h36,
			8'hF2, 8'hF3: is_pfx = 1'b1;
			default: is_pfx = 1'b0;
		endcase
		if (is_pfx && b0 != 8'hF2 && b0 != 8'hF3) begin
			b0 = b1;
			b1 = b2;
			b2 = next_insn[31:24];
			d_pfx = 2'd1;
		end
		mreg = b2[5:3];
		d_cls = `CDT_C_NONE;
		d_cond = b0[3:0];
		d_prot_only = 1'b0;
		d_clk = 16'd1;
		d_flags = 16'h0000;
		d_disp = 3'd0;
		if (b0[7:4] == 4'h7) begin
			// short branch, condition in the low nibble
			d_cls = `CDT_C_JCC;
			d_disp = 3'd1;
			d_clk = taken ? (prot ? 16'd6 : 16'd4) : 16'd1;
		end else if (b0 == 8'h0F && b1[7:4] == 4'h8) begin
			// long branch shares the condition code
			d_cls = `CDT_C_JCC;
			d_cond = b1[3:0];
			d_disp = 3'd4;
			d_clk = taken ? (prot ? 16'd6 : 16'd4) : 16'd1;
		end else if (b0 == 8'h0F) begin
			case (b1)
				8'h02: begin
					d_cls = `CDT_C_ARFETCH;
					d_prot_only = 1'b1;
					d_flags = 16'h0040;
					d_clk = use_mem ? 16'd12 : 16'd11;
				end
				8'h03: begin
					d_cls = `CDT_C_LIMFETCH;
					d_prot_only = 1'b1;
					d_flags = 16'h0040;
					d_clk = use_mem ? 16'd15 : 16'd14;
				end
				8'hB4, 8'hB5, 8'hB2: begin
					d_cls = `CDT_C_FARPTR;
					d_clk = prot ? 16'd19 : 16'd6;
				end
				8'h01: begin
					if (mreg == 3'b010 || mreg == 3'b011) begin
						d_cls = `CDT_C_GIDT;
						d_clk = 16'd9;
					end else if (mreg == 3'b110) begin
						d_cls = `CDT_C_MSW;
						d_clk = 16'd5;
					end
				end
				8'h00: begin
					if (mreg == 3'b010 || mreg == 3'b011) begin
						d_cls = `CDT_C_LDTTR;
						d_prot_only = 1'b1;
						d_clk = use_mem ? 16'd17 : 16'd16;
					end
				end
				8'h22: begin
					d_cls = `CDT_C_CRWR;
					// eee 000 is the slow control write
					d_clk = (mreg == 3'b000) ? 16'd11 : 16'd3;
				end
				8'h20: begin
					d_cls = `CDT_C_CRRD;
					d_clk = (mreg == 3'b000) ? 16'd1 : 16'd3;
				end
				8'h23: begin
					d_cls = `CDT_C_DRWR;
					d_clk = 16'd1;
				end
				8'h21: begin
					d_cls = `CDT_C_DRRD;
					d_clk = 16'd3;
				end
				8'h26: begin
					d_cls = `CDT_C_TRWR;
					d_clk = (mreg < 3'd6) ? 16'd5 : 16'd1;
				end
				8'h24: begin
					d_cls = `CDT_C_TRRD;
					d_clk = (mreg < 3'd6) ? 16'd5 : 16'd3;
				end
				8'hBE, 8'hBF: begin
					d_cls = `CDT_C_SEXT;
					d_clk = use_mem ? 16'd3 : 16'd1;
				end
				8'hB6, 8'hB7: begin
					d_cls = `CDT_C_ZEXT;
					d_clk = use_mem ? 16'd3 : 16'd2;
				end
				8'hA1, 8'hA9: begin
					d_cls = `CDT_C_POPSEG;
					d_clk = prot ? 16'd18 : 16'd4;
				end
				8'hA0, 8'hA8: begin
					d_cls = `CDT_C_PUSH;
					d_clk = 16'd2;
				end
				8'h79, 8'h7B: begin
					d_cls = `CDT_C_SMRST;
					d_clk = 16'd10;
				end
				8'hAA: begin
					d_cls = `CDT_C_SMEXIT;
					d_clk = 16'd76;
				end
				default: d_cls = `CDT_C_NONE;
			endcase
		end else begin
			mreg = b1[5:3];
			case (b0)
				8'h9F: begin
					d_cls = `CDT_C_FLAGSAH;
					d_clk = 16'd2;
				end
				8'hC5, 8'hC4: begin
					d_cls = `CDT_C_FARPTR;
					d_clk = prot ? 16'd19 : 16'd6;
				end
				8'h8D: begin
					d_cls = `CDT_C_ADDR;
					d_clk = use_index ? 16'd3 : 16'd2;
				end
				8'hE2, 8'hE0, 8'hE1: begin
					d_cls = `CDT_C_LOOP;
					d_disp = 3'd1;
					d_clk = taken ? (prot ? 16'd9 : 16'd7) : 16'd3;
				end
				8'h07, 8'h17, 8'h1F: begin
					d_cls = `CDT_C_POPSEG;
					d_clk = prot ? 16'd18 : 16'd4;
				end
				8'h8F: begin
					d_cls = `CDT_C_POPGEN;
					d_clk = use_mem ? 16'd5 : 16'd3;
				end
				8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F: begin
					d_cls = `CDT_C_POPGEN;
					d_clk = 16'd3;
				end
				8'h9D: begin
					d_cls = `CDT_C_STACK_PULL_FLAGS;
					d_flags = `CDT_F_ALLCTL;
					d_clk = 16'd4;
				end
				8'h61: begin
					d_cls = `CDT_C_STACK_PULL_ALL;
					d_clk = 16'd18;
				end
				8'h60: begin
					d_cls = `CDT_C_STACK_STORE_ALL;
					d_clk = 16'd17;
				end
				8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57,
				8'h06, 8'h0E, 8'h16, 8'h1E, 8'h68, 8'h6A, 8'h9C: begin
					d_cls = `CDT_C_PUSH;
					d_clk = 16'd2;
				end
				8'hFF: begin
					if (mreg == 3'b110) begin
						d_cls = `CDT_C_PUSH;
						d_clk = use_mem ? 16'd4 : 16'd2;
					end
				end
				8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hC0, 8'hC1: begin
					if (mreg == 3'b010 || mreg == 3'b011) begin
						d_cls = `CDT_C_RCx;
						d_flags = 16'h0801;
						d_clk = 16'd9;
					end
				end
				8'hF2, 8'hF3: begin
					// repeated strings cost a fixed part plus n times a step
					d_cls = `CDT_C_STRING;
					case (b1)
						8'hA4, 8'hA5: d_clk = 16'd5 + {n_cnt[13:0], 2'b00};
						8'hAA, 8'hAB: d_clk = 16'd3 + {n_cnt[13:0], 2'b00};
						8'hAC, 8'hAD: d_clk = 16'd4 + {n_cnt[13:0], 2'b00} + n_cnt;
						8'hA6, 8'hA7: begin
							d_clk = 16'd5 + {n_cnt[12:0], 3'b000};
							d_flags = `CDT_F_ALL;
						end
						8'hAE, 8'hAF: begin
							d_clk = 16'd4 + {n_cnt[13:0], 2'b00} + n_cnt;
							d_flags = `CDT_F_ALL;
						end
						default: d_cls = `CDT_C_NONE;
					endcase
					d_pfx = 2'd1;
				end
				8'hC3, 8'hC2: begin
					d_cls = `CDT_C_RETN;
					d_clk = 16'd10;
				end
				8'hCB, 8'hCA: begin
					d_cls = `CDT_C_RETF;
					d_clk = !prot ? 16'd13 : (cross_priv ? 16'd61 : 16'd26);
				end
				default: d_cls = `CDT_C_NONE;
			endcase
		end
	end
	// write channel capture and register update
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			ctrl <= `CDT_CTRL_RESET;
			insn <= 32'h0000_0000;
			ctx <= 32'h0000_0000;
		end else if (aclk_en) begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				case (aw_addr)
					`CDT_REG_CTRL: ctrl <= (ctrl & ~wmask) | (w_data & wmask & 32'h0000_0001);
					`CDT_REG_INSN: insn <= next_insn;
					`CDT_REG_CTX: ctx <= (ctx & ~wmask) | (w_data & wmask);
					`CDT_REG_STAT, `CDT_REG_CLKS, `CDT_REG_FLAGS: s_axi_bresp <= 2'b00;
					default: s_axi_bresp <= 2'b10; // unmapped address
				endcase
			end
		end
	end
	// decode results are captured with each instruction word write
	always @(posedge aclk) begin
		if (!aresetn) begin
			cls <= `CDT_C_NONE;
			cond <= 4'h0;
			invalid <= 1'b0;
			clocks <= 16'h0000;
			flag_mask <= 16'h0000;
			vector <= 8'h00;
			prefix_cnt <= 2'd0;
			disp_bytes <= 3'd0;
		end else if (aclk_en && wr_insn) begin
			cls <= d_cls;
			cond <= d_cond;
			prefix_cnt <= d_pfx;
			disp_bytes <= d_disp;
			// protected-only work in real mode faults instead of running
			if (d_prot_only && !prot) begin
				invalid <= 1'b1;
				vector <= `CDT_VEC_INVALID;
				clocks <= 16'h0000;
				flag_mask <= 16'h0000;
			end else begin
				invalid <= (d_cls == `CDT_C_NONE);
				vector <= (d_cls == `CDT_C_NONE) ? `CDT_VEC_INVALID : 8'h00;
				clocks <= d_clk;
				flag_mask <= d_flags;
			end
		end
	end
	// axi read path, one read under way at a time
	assign s_axi_arready = !s_axi_rvalid;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (aclk_en) begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr[7:0])
					`CDT_REG_CTRL: s_axi_rdata <= ctrl;
					`CDT_REG_INSN: s_axi_rdata <= insn;
					`CDT_REG_CTX: s_axi_rdata <= ctx;
					`CDT_REG_STAT: s_axi_rdata <= {vector, 7'd0, disp_bytes, 2'd0, prefix_cnt,
						invalid, cond, cls};
					`CDT_REG_CLKS: s_axi_rdata <= {16'h0000, clocks};
					`CDT_REG_FLAGS: s_axi_rdata <= {16'h0000, flag_mask};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end
		end
	end
endmodule // cdt_decode

/* verif/cdt_decode_asserts.sv */
// register port protocol checker for the opcode decode block
`timescale 1ns/1ps
module cdt_decode_asserts (
	input wire aclk,
	input wire aresetn,
	input wire aclk_en,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	// one clock domain, so clocking and reset gating are shared
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		aclk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_answer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	sequence s_rd_take;
		aclk_en && s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wr_answer;
		s_wr_take |=> s_b_answer;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_wr_refuse;
		s_wr_take |=> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr_refuse: assert property (p_wr_refuse) else $error("write channels reopened");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_b_drop;
		aclk_en && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop) else $error("write response repeated");
	property p_rd_answer;
		s_rd_take |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
			&& $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data changed");
	property p_ar_refuse;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
	// offsets past the flags register hold nothing
	property p_unmapped;
		s_rd_take and s_axi_araddr[7:0] > 8'h14 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule // cdt_decode_asserts

bind cdt_decode cdt_decode_asserts i_cdt_decode_asserts (.aclk(aclk), .aresetn(aresetn),
	.aclk_en(aclk_en), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* verif/cdt_decode_tb.sv */
// self-checking bench for the opcode decode block
`timescale 1ns/1ps
`include "cdt_map.vh"
module cdt_decode_tb;
	logic aclk, aresetn, aclk_en, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int err_total, total_checks;
	cdt_decode i_cdt_decode (.aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	// 200 MHz clock
	initial begin
		aclk = 0;
		forever #2.5 aclk = ~aclk;
	end
	task results;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// a slave that never answers ends the run as a failure
	task tmo(input int n);
		if (n > 100) begin
			err_total++;
			results();
		end
	endtask
	// signals are sampled mid-cycle, where they have settled since the edge;
	// an edge passes first so no strobe is lowered and raised in one step
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		int n;
		@(posedge aclk);
		awaddr <= {24'h00_0000, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			n++;
			tmo(n);
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		int n;
		@(posedge aclk);
		araddr <= {24'h00_0000, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(negedge aclk);
			ta = arvalid & arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			n++;
			tmo(n);
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end while (!tr);
		rready <= 1'b0;
	endtask
	// mode, context, opcode bytes, then expected clocks and flag mask
	task dec(input logic p, input logic [15:0] c, input logic [31:0] op,
		input logic [15:0] clk, input logic [15:0] fl);
		logic [31:0] d;
		logic [1:0] r;
		wr(`CDT_REG_CTRL, {31'h0, p}, r);
		wr(`CDT_REG_CTX, {16'h0000, c}, r);
		wr(`CDT_REG_INSN, op, r);
		chk("insn_resp", r, 0);
		rd(`CDT_REG_CLKS, d, r);
		chk("clocks", d[15:0], clk);
		rd(`CDT_REG_FLAGS, d, r);
		chk("flags", d[15:0], fl);
		rd(`CDT_REG_STAT, d, r);
		chk("invalid", d[9], 0);
	endtask
	task t_branch;
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 16; i++) begin
			dec(0, 16'h0000, 32'h0000_0070 + i, 1, '0);
			rd(`CDT_REG_STAT, d, r);
			chk("short_cond", d[8:0], {i[3:0], `CDT_C_JCC});
			dec(1, 16'h0001, {16'h0000, 4'h8, i[3:0], 8'h0F}, 6, '0);
			rd(`CDT_REG_STAT, d, r);
			chk("long_cond", d[8:0], {i[3:0], `CDT_C_JCC});
		end
		dec(0, 16'h0001, 32'h0000_0075, 4, '0);
	endtask
	task t_system;
		dec(0, 16'h0000, 32'h0000_009F, 2, '0);
		dec(1, 16'h0000, 32'h00C0_020F, 11, 16'h0040);
		dec(1, 16'h0004, 32'h0000_030F, 15, 16'h0040);
		dec(0, 16'h0000, 32'h0000_00C5, 6, '0);
		dec(1, 16'h0000, 32'h0000_B20F, 19, '0);
		dec(0, 16'h0000, 32'h0000_008D, 2, '0);
		dec(0, 16'h0002, 32'h0000_008D, 3, '0);
		dec(0, 16'h0000, 32'h00D0_010F, 9, '0);
		dec(1, 16'h0000, 32'h00D8_010F, 9, '0);
		dec(1, 16'h0004, 32'h0010_000F, 17, '0);
		dec(1, 16'h0000, 32'h00D8_000F, 16, '0);
		dec(0, 16'h0000, 32'h00F0_010F, 5, '0);
		dec(0, 16'h0001, 32'h0000_00E2, 7, '0);
		dec(1, 16'h0001, 32'h0000_00E0, 9, '0);
		dec(0, 16'h0000, 32'h0000_00E1, 3, '0);
		dec(0, 16'h0000, 32'h00C0_220F, 11, '0);
		dec(0, 16'h0000, 32'h00D0_220F, 3, '0);
		dec(0, 16'h0000, 32'h00C0_210F, 3, '0);
		dec(0, 16'h0000, 32'h00D8_260F, 5, '0);
		dec(0, 16'h0004, 32'h0000_BE0F, 3, '0);
		dec(0, 16'h0000, 32'h00C0_B60F, 2, '0);
	endtask
	task t_stack;
		logic [71:0] pf;
		pf = 72'hF0_6766_2E3E_2664_6536;
		dec(1, 16'h0000, 32'h0000_0007, 18, '0);
		dec(0, 16'h0000, 32'h0000_001F, 4, '0);
		dec(0, 16'h0004, 32'h0000_008F, 5, '0);
		dec(0, 16'h0000, 32'h0000_0058, 3, '0);
		dec(0, 16'h0000, 32'h0000_009D, 4, 16'h0FD5);
		dec(0, 16'h0000, 32'h0000_0061, 18, '0);
		for (int k = 0; k < 9; k++)
			dec(0, 16'h0000, {16'h0000, 8'h9F, pf[8*k +: 8]}, 2, '0);
		dec(0, 16'h0000, 32'h0000_0060, 17, '0);
		dec(0, 16'h0000, 32'h0000_009C, 2, '0);
		dec(0, 16'h0004, 32'h0000_30FF, 4, '0);
		dec(0, 16'h0000, 32'h0000_D0D1, 9, 16'h0801);
		dec(0, 16'h0004, 32'h0000_18D3, 9, 16'h0801);
	endtask
	task t_repeat;
		dec(0, 16'h0300, 32'h0000_A5F2, 17, '0);
		dec(0, 16'h0000, 32'h0000_A5F2, 5, '0);
		dec(0, 16'h0200, 32'h0000_ABF2, 11, '0);
		dec(0, 16'h0100, 32'h0000_ADF2, 9, '0);
		dec(0, 16'h0200, 32'h0000_A7F3, 21, 16'h08D5);
		dec(0, 16'h0200, 32'h0000_AFF2, 14, 16'h08D5);
		dec(0, 16'h0000, 32'h0000_00C3, 10, '0);
		dec(0, 16'h0000, 32'h0000_00CA, 13, '0);
		dec(1, 16'h0000, 32'h0000_00CB, 26, '0);
		dec(1, 16'h0008, 32'h0000_00CB, 61, '0);
		dec(0, 16'h0000, 32'h0018_790F, 10, '0);
		dec(1, 16'h0000, 32'h0000_AA0F, 76, '0);
	endtask
	// protected-only opcodes in real mode, then refused and read-only places
	task t_refuse;
		logic [31:0] d;
		logic [1:0] r;
		logic [95:0] ops;
		ops = 96'h0000_020F_0000_030F_00D0_000F;
		for (int k = 0; k < 3; k++) begin
			wr(`CDT_REG_CTRL, 32'h0000_0000, r);
			wr(`CDT_REG_INSN, ops[32*k +: 32], r);
			rd(`CDT_REG_STAT, d, r);
			chk("invalid_vec", {d[31:24], d[9]}, {`CDT_VEC_INVALID, 1'b1});
		end
		rd(8'h40, d, r);
		chk("unmapped_rd", {r, d}, {2'b10, 32'h0000_0000});
		wr(8'h40, 32'h0000_0001, r);
		chk("unmapped_wr", r, 2'b10);
		wr(`CDT_REG_STAT, 32'hFFFF_FFFF, r);
		rd(`CDT_REG_STAT, d, r);
		chk("stat_ro", d[31:24], `CDT_VEC_INVALID);
	endtask
	// a low enable freezes the port: a pending read waits until it rises
	task t_freeze;
		logic [31:0] d;
		logic ta, tr;
		int n;
		@(posedge aclk);
		aclk_en <= 1'b0;
		araddr <= {24'h00_0000, `CDT_REG_CTRL};
		arvalid <= 1'b1;
		rready <= 1'b1;
		repeat (3) @(negedge aclk);
		chk("frozen_rvalid", rvalid, 1'b0);
		@(posedge aclk);
		aclk_en <= 1'b1;
		n = 0;
		do begin
			@(negedge aclk);
			ta = arvalid & arready & aclk_en;
			tr = rvalid;
			d = rdata;
			n++;
			tmo(n);
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end while (!tr);
		rready <= 1'b0;
		chk("thawed_ctrl", d, 32'h0000_0000);
	endtask
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		err_total = 0;
		total_checks = 0;
		aresetn = 0;
		aclk_en = 1;
		awaddr = 0;
		awvalid = 0;
		wdata = 0;
		wstrb = 4'hF;
		wvalid = 0;
		bready = 0;
		araddr = 0;
		arvalid = 0;
		rready = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`CDT_REG_CTRL, d, r);
		chk("ctrl_reset", {r, d}, {2'b00, `CDT_CTRL_RESET});
		t_branch();
		t_system();
		t_stack();
		t_repeat();
		t_refuse();
		t_freeze();
		results();
	end
endmodule // cdt_decode_tb
